/* verilog/ieh_pkg.sv */
// Package of constants and types for the I2C exception and recovery handler.
package ieh_pkg;

   // APB register byte offsets.
   localparam logic [7:0] OFS_STATUS   = 8'h00;
   localparam logic [7:0] OFS_CONTROL  = 8'h04;
   localparam logic [7:0] OFS_COUNT    = 8'h08;
   localparam logic [7:0] OFS_TIMEOUT  = 8'h0c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   localparam logic [7:0] OFS_SRESET   = 8'h18;

   // Field positions of the bus control register.
   localparam int CTL_OSC = 7;
   localparam int CTL_STA = 5;
   localparam int CTL_STO = 4;
   localparam int CTL_SI  = 3;
   localparam int CTL_AA  = 2;
   localparam int CTL_GC  = 1;

   // Interrupt status and mask bit positions.
   localparam int IRQ_UPD = 0;
   localparam int IRQ_ERR = 1;
   localparam int IRQ_CNT = 2;

   // Reset values and keys.
   localparam logic [7:0]  CTL_RST   = 8'h00;
   localparam logic [6:0]  COUNT_RST = 7'h01;
   localparam logic [15:0] TMO_RST   = 16'h0fa0;
   localparam logic [2:0]  IRQ_RST   = 3'h0;
   localparam logic [7:0]  SRST_KEY  = 8'ha5;

   // Legal byte count range.
   localparam logic [6:0] COUNT_MIN = 7'h01;
   localparam logic [6:0] COUNT_MAX = 7'h44;

   // Status codes.
   localparam logic [7:0] ST_IDLE     = 8'hf8;
   localparam logic [7:0] ST_BUS_ERR  = 8'h00;
   localparam logic [7:0] ST_SDA_LOW  = 8'h70;
   localparam logic [7:0] ST_SCL_LOW  = 8'h78;
   localparam logic [7:0] ST_BAD_CNT  = 8'hfc;
   localparam logic [7:0] ST_STARTED  = 8'h08;
   localparam logic [7:0] ST_ARB_MT   = 8'h38;
   localparam logic [7:0] ST_ARB_MR   = 8'h68;
   localparam logic [7:0] ST_ARB_SL   = 8'hb0;

   // Recovery clocking: a quarter of a 100 kHz bit, and nine recovery pulses.
   localparam int         CLK_NS      = 50;
   localparam int         QTR_NS      = 2500;
   localparam int         QTR_CYC     = (QTR_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] RECOV_PULSES = 4'h9;

   typedef enum logic [8:0] {
      S_IDLE  = 9'b000000001,
      S_WAIT  = 9'b000000010,
      S_CHECK = 9'b000000100,
      S_START = 9'b000001000,
      S_RECOV = 9'b000010000,
      S_STOP  = 9'b000100000,
      S_MAST  = 9'b001000000,
      S_ARB   = 9'b010000000,
      S_ERR   = 9'b100000000
   } ieh_state_t;

endpackage

/* verilog/ieh_line_if.sv */
// Interface carrying the filtered bus levels and detected bus conditions.
`timescale 1ns/1ps
interface ieh_line_if;
   logic scl;
   logic sda;
   logic start_det;
   logic stop_det;
   modport src (output scl, output sda, output start_det, output stop_det);
   modport dst (input scl, input sda, input start_det, input stop_det);
endinterface

/* verilog/ieh_line_sync.sv */
// Three-stage pin synchroniser with START and STOP detection.
`timescale 1ns/1ps
module ieh_line_sync (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic scl_in,
   input wire logic sda_in,
   ieh_line_if.src  line
);
   logic [2:0] scl_sh_reg;
   logic [2:0] sda_sh_reg;
   logic       scl_f_reg;
   logic       sda_f_reg;
   logic       start_reg;
   logic       stop_reg;

   // Stage 0 feeds only stage 1; a level is accepted once stages 1 and 2 agree.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_sh_reg <= 3'h7;
         sda_sh_reg <= 3'h7;
      end else begin
         scl_sh_reg <= {scl_sh_reg[1:0], scl_in};
         sda_sh_reg <= {sda_sh_reg[1:0], sda_in};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_f_reg <= 1'b1;
         sda_f_reg <= 1'b1;
         start_reg <= 1'b0;
         stop_reg  <= 1'b0;
      end else begin
         if (scl_sh_reg[1] == scl_sh_reg[2]) begin
            scl_f_reg <= scl_sh_reg[2];
         end
         if (sda_sh_reg[1] == sda_sh_reg[2]) begin
            sda_f_reg <= sda_sh_reg[2];
         end
         // Data edges while clock is high are conditions, not data.
         start_reg <= scl_f_reg && sda_f_reg && (sda_sh_reg[1] == sda_sh_reg[2])
                      && !sda_sh_reg[2] && (scl_sh_reg[2] || scl_sh_reg[1]);
         stop_reg  <= scl_f_reg && !sda_f_reg && (sda_sh_reg[1] == sda_sh_reg[2])
                      && sda_sh_reg[2] && (scl_sh_reg[2] || scl_sh_reg[1]);
      end
   end

   assign line.scl       = scl_f_reg;
   assign line.sda       = sda_f_reg;
   assign line.start_det = start_reg;
   assign line.stop_det  = stop_reg;
endmodule

/* verilog/ieh_top.sv */
// Exception, recovery and forced-access handler of an APB to I2C controller.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/1ps
module ieh_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        scl_in,
   output logic             scl_out,
   output logic             scl_oe,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        xfer_involved,
   input  wire logic        xfer_in_frame,
   input  wire logic        xfer_done,
   input  wire logic        rs_pending,
   input  wire logic        arb_lost,
   input  wire logic [1:0]  arb_lost_kind,
   output logic             own_addr_en,
   output logic             gen_call_en,
   output logic             stop_request,
   output logic             start_sent,
   output logic             rs_adopted,
   output logic             irq
);
   import ieh_pkg::*;

   ieh_line_if line ();

   ieh_line_sync u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .scl_in  (scl_in),
      .sda_in  (sda_in),
      .line    (line)
   );

   ieh_state_t  state_reg;
   ieh_state_t  state_next;
   logic [7:0]  status_reg;
   logic [7:0]  ctl_reg;
   logic [6:0]  count_reg;
   logic [15:0] tmo_reg;
   logic [2:0]  irq_st_reg;
   logic [2:0]  irq_mask_reg;
   logic        srst_reg;
   logic        busy_reg;
   logic [15:0] idle_cnt_reg;
   logic [15:0] low_cnt_reg;
   logic [7:0]  qcnt_reg;
   logic [1:0]  phase_reg;
   logic [3:0]  pulse_reg;
   logic        qtick;
   logic        wr_acc;
   logic        rd_set;
   logic        count_bad;
   logic        bus_err;
   logic        scl_stuck;
   logic        idle_tmo;
   logic        seq_end;
   logic        drv_scl;
   logic        drv_sda;
   logic        load_code;
   logic [7:0]  code_next;

   assign pready  = 1'b1;
   assign sda_out = 1'b0;
   assign scl_out = 1'b0;
   assign wr_acc  = psel && penable && pwrite;
   assign rd_set  = psel && !penable;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == OFS_STATUS) || (a == OFS_CONTROL) || (a == OFS_COUNT) ||
               (a == OFS_TIMEOUT) || (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK) ||
               (a == OFS_SRESET);
   endfunction

   assign pslverr   = psel && penable && !mapped(paddr);
   assign count_bad = (count_reg < COUNT_MIN) || (count_reg > COUNT_MAX);
   assign qtick     = (qcnt_reg == 8'(QTR_CYC - 1));
   assign seq_end   = qtick && (phase_reg == 2'h3);
   // Both time-outs compare against the software time-out setting.
   assign idle_tmo  = (idle_cnt_reg >= tmo_reg);
   assign scl_stuck = (low_cnt_reg >= tmo_reg) && (state_reg != S_ERR);
   // Misplaced conditions matter only while this device takes part in a frame.
   assign bus_err   = xfer_involved && xfer_in_frame && (line.start_det || line.stop_det)
                      && (state_reg != S_ERR);

   // Address recognition enables for the transfer engine while idle.
   assign own_addr_en  = (state_reg == S_IDLE) && !ctl_reg[CTL_STA] && ctl_reg[CTL_AA];
   assign gen_call_en  = (state_reg == S_IDLE) && !ctl_reg[CTL_STA] && ctl_reg[CTL_GC];
   assign stop_request = ctl_reg[CTL_STO];
   assign irq          = |(irq_st_reg & irq_mask_reg);

   always_comb begin
      state_next = state_reg;
      load_code  = 1'b0;
      code_next  = status_reg;
      unique case (state_reg)
         S_IDLE: begin
            if (ctl_reg[CTL_STA] && !ctl_reg[CTL_SI]) begin
               state_next = busy_reg ? S_WAIT : S_CHECK;
            end
         end
         S_WAIT: begin
            if (!busy_reg || idle_tmo) begin
               state_next = S_CHECK;
            end
         end
         S_CHECK: begin
            if (seq_end) begin
               state_next = line.sda ? S_START : S_RECOV;
            end
         end
         S_START: begin
            if (seq_end) begin
               state_next = S_MAST;
               load_code  = 1'b1;
               code_next  = ST_STARTED;
            end
         end
         S_RECOV: begin
            if (seq_end && (pulse_reg == RECOV_PULSES - 4'h1)) begin
               state_next = S_STOP;
            end
         end
         S_STOP: begin
            if (seq_end) begin
               if (line.sda) begin
                  state_next = S_START;
               end else begin
                  state_next = S_ERR;
                  load_code  = 1'b1;
                  code_next  = ST_SDA_LOW;
               end
            end
         end
         S_MAST: begin
            if (arb_lost) begin
               state_next = S_ARB;
               load_code  = 1'b1;
               unique case (arb_lost_kind)
                  2'h0:    code_next = ST_ARB_MT;
                  2'h1:    code_next = ST_ARB_MR;
                  default: code_next = ST_ARB_SL;
               endcase
            end else if (xfer_done) begin
               state_next = S_IDLE;
               code_next  = ST_IDLE;
            end
         end
         S_ARB: begin
            // Barring a stuck SCL, a bus error or a soft reset, only a foreign STOP or a quiet bus ends arbitration loss.
            if (line.stop_det || idle_tmo) begin
               state_next = ctl_reg[CTL_STA] ? S_CHECK : S_IDLE;
               code_next  = ctl_reg[CTL_STA] ? status_reg : ST_IDLE;
            end
         end
         S_ERR: begin
            state_next = S_ERR;
         end
      endcase
      if (scl_stuck) begin
         state_next = S_ERR;
         load_code  = 1'b1;
         code_next  = ST_SCL_LOW;
      end else if (bus_err) begin
         state_next = S_ERR;
         load_code  = 1'b1;
         code_next  = ST_BUS_ERR;
      end else if (state_next == S_IDLE) begin
         load_code  = count_bad && (status_reg != ST_BAD_CNT);
         code_next  = count_bad ? ST_BAD_CNT : ST_IDLE;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg  <= S_IDLE;
         status_reg <= ST_IDLE;
      end else if (srst_reg) begin
         state_reg  <= S_IDLE;
         status_reg <= ST_IDLE;
      end else begin
         state_reg  <= state_next;
         status_reg <= code_next;
      end
   end

   // Quarter-bit enable and phase sequencer for generated conditions.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qcnt_reg  <= 8'h00;
         phase_reg <= 2'h0;
         pulse_reg <= 4'h0;
      end else if (srst_reg || !(state_reg inside {S_CHECK, S_START, S_RECOV, S_STOP})) begin
         qcnt_reg  <= 8'h00;
         phase_reg <= 2'h0;
         pulse_reg <= 4'h0;
      end else begin
         qcnt_reg <= qtick ? 8'h00 : qcnt_reg + 8'h01;
         if (qtick) begin
            phase_reg <= phase_reg + 2'h1;
         end
         if (seq_end && (state_reg == S_RECOV)) begin
            pulse_reg <= pulse_reg + 4'h1;
         end
      end
   end

   always_comb begin
      drv_scl = 1'b0;
      drv_sda = 1'b0;
      unique case (state_reg)
         S_START: begin
            drv_sda = (phase_reg != 2'h0);
            drv_scl = (phase_reg == 2'h3);
         end
         S_RECOV: begin
            drv_scl = !phase_reg[1];
         end
         S_STOP: begin
            drv_scl = (phase_reg == 2'h0);
            drv_sda = (phase_reg <= 2'h1);
         end
         default: begin
            drv_scl = 1'b0;
         end
      endcase
   end

   // Errors and idle leave both lines released.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         scl_oe <= drv_scl && !srst_reg;
         sda_oe <= drv_sda && !srst_reg;
      end
   end

   // Bus busy tracking and time-out counters.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg     <= 1'b0;
         idle_cnt_reg <= 16'h0000;
         low_cnt_reg  <= 16'h0000;
      end else begin
         if (line.start_det) begin
            busy_reg <= 1'b1;
         end else if (line.stop_det || srst_reg) begin
            busy_reg <= 1'b0;
         end
         if (line.scl && line.sda && (state_reg inside {S_WAIT, S_ARB})) begin
            idle_cnt_reg <= (idle_cnt_reg == 16'hffff) ? idle_cnt_reg : idle_cnt_reg + 16'h1;
         end else begin
            idle_cnt_reg <= 16'h0000;
         end
         // Our own recovery pulses must not look like a stuck clock.
         if (!line.scl && !scl_oe && !srst_reg) begin
            low_cnt_reg <= (low_cnt_reg == 16'hffff) ? low_cnt_reg : low_cnt_reg + 16'h1;
         end else begin
            low_cnt_reg <= 16'h0000;
         end
      end
   end

   // One-cycle notifications to the transfer engine.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_sent <= 1'b0;
         rs_adopted <= 1'b0;
      end else begin
         start_sent <= (state_reg == S_START) && (state_next == S_MAST);
         rs_adopted <= (state_reg == S_MAST) && rs_pending && line.start_det;
      end
   end

   // Software registers; hardware updates of the flag win over software clears.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_reg   <= CTL_RST;
         count_reg <= COUNT_RST;
         tmo_reg   <= TMO_RST;
         srst_reg  <= 1'b0;
      end else if (srst_reg) begin
         ctl_reg   <= CTL_RST;
         count_reg <= COUNT_RST;
         tmo_reg   <= TMO_RST;
         srst_reg  <= 1'b0;
      end else begin
         srst_reg <= wr_acc && (paddr == OFS_SRESET) && (pwdata[7:0] == SRST_KEY);
         if (wr_acc && (paddr == OFS_CONTROL)) begin
            ctl_reg <= pwdata[7:0];
         end
         if (wr_acc && (paddr == OFS_COUNT)) begin
            count_reg <= pwdata[6:0];
         end
         if (wr_acc && (paddr == OFS_TIMEOUT)) begin
            tmo_reg <= pwdata[15:0];
         end
         if (start_sent || (state_reg == S_START && state_next == S_MAST)) begin
            ctl_reg[CTL_STA] <= 1'b0;
         end
         if (load_code) begin
            ctl_reg[CTL_SI] <= 1'b1;
         end
      end
   end

   // Sticky event bits, write one to clear, set wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st_reg   <= IRQ_RST;
         irq_mask_reg <= IRQ_RST;
      end else if (srst_reg) begin
         irq_st_reg   <= IRQ_RST;
         irq_mask_reg <= IRQ_RST;
      end else begin
         if (wr_acc && (paddr == OFS_IRQ_MASK)) begin
            irq_mask_reg <= pwdata[2:0];
         end
         irq_st_reg <= (irq_st_reg & ~((wr_acc && paddr == OFS_IRQ_STAT) ? pwdata[2:0] : 3'h0))
                       | {load_code && (code_next == ST_BAD_CNT),
                          load_code && (state_next == S_ERR),
                          load_code};
      end
   end

   // Read data is captured in the setup cycle so the access cycle needs no wait.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_set && !pwrite) begin
         unique case (paddr)
            OFS_STATUS:   prdata <= {24'h000000, status_reg};
            OFS_CONTROL:  prdata <= {24'h000000, ctl_reg};
            OFS_COUNT:    prdata <= {25'h0000000, count_reg};
            OFS_TIMEOUT:  prdata <= {16'h0000, tmo_reg};
            OFS_IRQ_STAT: prdata <= {29'h00000000, irq_st_reg};
            OFS_IRQ_MASK: prdata <= {29'h00000000, irq_mask_reg};
            default:      prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule

/* tb/ieh_top_sva.sv */
// Port-level checker of the exception handler, bound to its top module.
`timescale 1ns/1ps
module ieh_top_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        scl_oe,
   input wire logic        sda_oe,
   input wire logic        xfer_involved,
   input wire logic        xfer_in_frame,
   input wire logic        rs_pending,
   input wire logic        own_addr_en,
   input wire logic        gen_call_en,
   input wire logic        start_sent,
   input wire logic        rs_adopted,
   input wire logic        irq
);
   import ieh_pkg::*;
   logic       aa_reg;
   logic       gc_reg;
   logic [2:0] mask_reg;
   logic [1:0] srst_reg;
   logic       wr_ok;
   assign wr_ok = psel && penable && pwrite && pready;
   // The shadow clears after the soft reset has landed, so it is never ahead of the design.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aa_reg   <= 1'b0;
         gc_reg   <= 1'b0;
         mask_reg <= 3'h0;
         srst_reg <= 2'h0;
      end else begin
         srst_reg <= {srst_reg[0], wr_ok && paddr == OFS_SRESET && pwdata[7:0] == SRST_KEY};
         if (srst_reg[1]) begin
            aa_reg   <= 1'b0;
            gc_reg   <= 1'b0;
            mask_reg <= 3'h0;
         end else if (wr_ok && paddr == OFS_CONTROL) begin
            aa_reg <= pwdata[CTL_AA];
            gc_reg <= pwdata[CTL_GC];
         end else if (wr_ok && paddr == OFS_IRQ_MASK) begin
            mask_reg <= pwdata[2:0];
         end
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_OWN_ADDR: assert property (!aa_reg |-> !own_addr_en)
      else $error("own address recognised with acknowledge off");
   AST_GEN_CALL: assert property (!gc_reg |-> !gen_call_en)
      else $error("general call recognised while disabled");
   AST_IRQ_MASK: assert property (irq |-> mask_reg != 3'h0)
      else $error("interrupt raised with every source masked");
   AST_APB_RESP: assert property (psel && penable |-> pready &&
      pslverr == (paddr[1:0] != 2'h0 || paddr > OFS_SRESET))
      else $error("wrong response for access");
   AST_START_PULSE: assert property (start_sent |=> !start_sent)
      else $error("start indication longer than one cycle");
   AST_RS_ADOPT: assert property (rs_adopted |-> $past(rs_pending) ##1 !rs_adopted)
      else $error("repeated start adopted without own pending one");
   AST_RESET_REL: assert property ($rose(presetn) |-> !scl_oe && !sda_oe && !start_sent)
      else $error("bus driven right after reset");
   AST_BUS_ERR: assert property (xfer_involved && xfer_in_frame && scl_in && $fell(sda_in)
      |-> ##[2:12] (!scl_oe && !sda_oe))
      else $error("lines not released after misplaced start");
endmodule
bind ieh_top ieh_top_chk u_chk (.*);

/* tb/ieh_bus_model.sv */
// Behavioural model of the other masters and slaves on the two-wire bus.
`timescale 1ns/1ps
module ieh_bus_model (
   input  wire logic scl_oe,
   input  wire logic sda_oe,
   input  wire logic stuck_scl,
   input  wire logic stuck_sda,
   output logic      scl_in,
   output logic      sda_in
);
   logic scl_drv = 1'b0;
   logic sda_drv = 1'b0;
   // Pull-ups make a released line read high; whoever pulls low wins.
   assign scl_in = !(scl_oe || scl_drv || stuck_scl);
   assign sda_in = !(sda_oe || sda_drv || stuck_sda);
   // Leaves the bus busy with both lines released, as a stray START does.
   task automatic send_start();
      sda_drv = 1'b1;
      #200 scl_drv = 1'b1;
      #200 sda_drv = 1'b0;
      #200 scl_drv = 1'b0;
      #200;
   endtask
   task automatic send_stop();
      scl_drv = 1'b1;
      #200 sda_drv = 1'b1;
      #200 scl_drv = 1'b0;
      #200 sda_drv = 1'b0;
      #200;
   endtask
endmodule

/* tb/test_i2c_exception_state_handler.sv */
// Self-checking bench of the I2C exception and recovery handler.
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module test_i2c_exception_state_handler;
   import ieh_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, slverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, stuck_scl, stuck_sda;
   logic        xfer_involved, xfer_in_frame, xfer_done, rs_pending, arb_lost, rs_seen;
   logic [1:0]  arb_lost_kind;
   logic        own_addr_en, gen_call_en, stop_request, start_sent, rs_adopted, irq;
   int          err_count = 0, check_count = 0, cycles = 0, pulses = 0, waited;
   logic [6:0]  cnt_tab [5] = '{7'h00, 7'h45, 7'h44, 7'h7f, 7'h01};
   logic [7:0]  arb_tab [4] = '{ST_ARB_MT, ST_ARB_MR, ST_ARB_SL, ST_ARB_SL};
   ieh_top dut (.*);
   ieh_bus_model bus (.scl_oe, .sda_oe, .stuck_scl, .stuck_sda, .scl_in, .sda_in);
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) if (rs_adopted === 1'b1) rs_seen <= 1'b1;
   always @(posedge scl_oe) pulses++;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 40000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   function automatic logic [31:0] bitv(input int b);
      return 32'h1 << b;
   endfunction
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input string n);
      apb(1'b0, a, 32'h0);
      `CHK(n, e, rd)
   endtask
   task automatic poll(input logic [7:0] code, input int lim);
      apb(1'b0, OFS_STATUS, 32'h0);
      for (int i = 0; i < lim && rd !== {24'h0, code}; i++) apb(1'b0, OFS_STATUS, 32'h0);
      `CHK("status", {24'h0, code}, rd)
   endtask
   task automatic wait_start();
      for (waited = 0; waited < 3000 && start_sent !== 1'b1; waited++) @(posedge pclk);
      `CHK("start_sent", 1'b1, start_sent)
   endtask
   task automatic soft_reset();
      apb(1'b1, OFS_SRESET, {24'h0, SRST_KEY});
      @(posedge pclk);
   endtask
   task automatic hw_reset();
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, stuck_scl, stuck_sda} = '0;
      {xfer_involved, xfer_in_frame, xfer_done, rs_pending, arb_lost, arb_lost_kind, rs_seen} = '0;
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      chk_rd(OFS_STATUS, {24'h0, ST_IDLE}, "status");
      chk_rd(OFS_CONTROL, {24'h0, CTL_RST}, "control");
      chk_rd(OFS_COUNT, {25'h0, COUNT_RST}, "count");
      chk_rd(OFS_TIMEOUT, {16'h0, TMO_RST}, "timeout");
      chk_rd(OFS_IRQ_MASK, 32'h0, "mask");
      chk_rd(8'h1c, 32'h0, "unmapped");
      `CHK("pslverr", 1'b1, slverr)
      apb(1'b1, OFS_TIMEOUT, 32'h14);
      chk_rd(OFS_TIMEOUT, 32'h14, "timeout");
      foreach (cnt_tab[i]) begin
         apb(1'b1, OFS_COUNT, {25'h0, cnt_tab[i]});
         poll((cnt_tab[i] >= COUNT_MIN && cnt_tab[i] <= COUNT_MAX) ? ST_IDLE : ST_BAD_CNT, 20);
      end
      apb(1'b1, OFS_CONTROL, bitv(CTL_GC) | bitv(CTL_STO));
      @(negedge pclk);
      `CHK("stop_request", 1'b1, stop_request)
      `CHK("own_addr_en", 1'b0, own_addr_en)
      `CHK("gen_call_en", 1'b1, gen_call_en)
      apb(1'b1, OFS_CONTROL, bitv(CTL_AA));
      @(negedge pclk);
      `CHK("own_addr_en", 1'b1, own_addr_en)
      `CHK("gen_call_en", 1'b0, gen_call_en)
      `CHK("stop_request", 1'b0, stop_request)
      apb(1'b1, OFS_CONTROL, bitv(CTL_STA));
      wait_start();
      poll(ST_STARTED, 5);
      rs_pending <= 1'b1;
      bus.send_start();
      repeat (10) @(posedge pclk);
      `CHK("rs_adopted", 1'b1, rs_seen)
      rs_pending <= 1'b0;
      for (int k = 3; k >= 0; k--) begin
         if (k < 3) begin
            soft_reset();
            apb(1'b1, OFS_CONTROL, bitv(CTL_STA));
            wait_start();
         end
         arb_lost_kind <= k[1:0];
         arb_lost <= 1'b1;
         @(posedge pclk);
         arb_lost <= 1'b0;
         poll(arb_tab[k], 5);
      end
      apb(1'b1, OFS_CONTROL, bitv(CTL_STA));
      repeat (100) @(posedge pclk);
      poll(ST_ARB_MT, 1);
      bus.send_stop();
      wait_start();
      poll(ST_STARTED, 5);
      xfer_done <= 1'b1;
      @(posedge pclk);
      xfer_done <= 1'b0;
      poll(ST_IDLE, 5);
      soft_reset();
      apb(1'b1, OFS_TIMEOUT, 32'h190);
      bus.send_start();
      apb(1'b1, OFS_CONTROL, bitv(CTL_STA));
      wait_start();
      `CHK("forced_wait", 1'b1, waited >= 380)
      soft_reset();
      xfer_in_frame <= 1'b1;
      bus.send_start();
      poll(ST_IDLE, 1);
      xfer_involved <= 1'b1;
      bus.send_start();
      poll(ST_BUS_ERR, 5);
      `CHK("lines_released", 2'h0, {scl_oe, sda_oe})
      `CHK("drive_levels", 2'h0, {scl_out, sda_out})
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      `CHK("error_event", 1'b1, rd[IRQ_ERR])
      `CHK("irq_masked", 1'b0, irq)
      apb(1'b1, OFS_IRQ_MASK, bitv(IRQ_ERR));
      @(negedge pclk);
      `CHK("irq_raised", 1'b1, irq)
      apb(1'b1, OFS_IRQ_STAT, 32'h7);
      @(negedge pclk);
      `CHK("irq_cleared", 1'b0, irq)
      apb(1'b1, OFS_CONTROL, bitv(CTL_STA));
      poll(ST_BUS_ERR, 1);
      {xfer_involved, xfer_in_frame} <= 2'h0;
      soft_reset();
      poll(ST_IDLE, 5);
      bus.send_stop();
      poll(ST_IDLE, 1);
      apb(1'b1, OFS_TIMEOUT, 32'h14);
      stuck_scl <= 1'b1;
      poll(ST_SCL_LOW, 20);
      stuck_scl <= 1'b0;
      repeat (50) @(posedge pclk);
      poll(ST_SCL_LOW, 1);
      hw_reset();
      poll(ST_IDLE, 1);
      // SDA falling on an idle bus reads as a foreign START and leaves the bus busy for good.
      // The request therefore goes first, and SDA sticks while the line check runs.
      apb(1'b1, OFS_CONTROL, bitv(CTL_STA));
      stuck_sda <= 1'b1;
      pulses = 0;
      poll(ST_SDA_LOW, 1500);
      `CHK("recovery_pulses", 1'b1, pulses >= 9 && pulses <= 10)
      `CHK("lines_released", 2'h0, {scl_oe, sda_oe})
      stuck_sda <= 1'b0;
      hw_reset();
      poll(ST_IDLE, 1);
      end_of_test();
   end
endmodule
